/* phase_drive_regs.svh */
// Constants for the phase drive and multifunction pin block
`ifndef PHASE_DRIVE_REGS_SVH
`define PHASE_DRIVE_REGS_SVH
// Multifunction pin modes
`define MF_MODE_CHAN_B_EN  2'h0
`define MF_MODE_VOUT_RESET 2'h1
`define MF_MODE_SYNC       2'h2
// Telemetry scale (millivolts)
`define TEMP_OFFSET_MV     16'd600
`define TEMP_STEP_MV       16'd8
`define ISENSE_GAIN_MV_PER_A 16'd5
// Timing, PLL error reset and default phase count
`define CLK_PERIOD_NS      50
`define PLL_ERR_RESET      16'h0000
`define PHASE_COUNT_DEF    7
`endif

/* phase_drive_pkg.sv */
// Types for the phase drive block
`default_nettype none
package phase_drive_pkg;
	typedef enum logic [1:0] {
		ph_off,
		ph_high,
		ph_low
	} phase_state_type;
endpackage
`default_nettype wire

/* sync_pll.sv */
// Edge synchronisation loop that trims on-time
`default_nettype none
`include "phase_drive_regs.svh"
module sync_pll #(
	parameter int unsigned W = 16
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	// Control
	input  wire logic         enable_i,
	input  wire logic [3:0]   div_ratio_i,
	input  wire logic [W-1:0] phase_shift_i,
	input  wire logic [3:0]   gain_shift_i,
	// Edges
	input  wire logic         sync_edge_i,
	input  wire logic         pwm0_edge_i,
	// Trim out
	output logic signed [W-1:0] trim_o,
	output logic              locked_o
);
	// ****************************************
	// Edge divider and phase error
	// ****************************************
	logic [3:0]          div_q;
	logic                ref_tick;
	logic [W-1:0]        cnt_q;
	logic signed [W-1:0] err_q;
	logic signed [W-1:0] acc_q;
	if (W < 8) begin : g_bad_w
		$error("sync_pll width too small");
	end
	assign ref_tick = sync_edge_i && (div_q == div_ratio_i);
	always_ff @(posedge clk_i) begin
		if (!nrst_i || !enable_i) begin
			div_q <= 4'h0;
		end else if (sync_edge_i) begin
			div_q <= (div_q == div_ratio_i) ? 4'h0 : div_q + 4'h1;
		end
	end
	// Counter from reference edge to order 0 rising edge
	always_ff @(posedge clk_i) begin
		if (!nrst_i || !enable_i || ref_tick) begin
			cnt_q <= '0;
		end else if (cnt_q != '1) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (!nrst_i || !enable_i) begin
			err_q <= `PLL_ERR_RESET;
		end else if (pwm0_edge_i) begin
			err_q <= $signed(cnt_q - phase_shift_i);
		end
	end
	// Slow integrator; gain sets loop bandwidth
	always_ff @(posedge clk_i) begin
		if (!nrst_i || !enable_i) begin
			acc_q <= '0;
		end else if (pwm0_edge_i) begin
			acc_q <= acc_q - (err_q >>> gain_shift_i);
		end
	end
	assign trim_o   = acc_q;
	assign locked_o = enable_i && (err_q < 16 && err_q > -16);
endmodule
`default_nettype wire

/* phase_drive_sync_and_pin_mux.sv */
// Phase PWM drive, stage fault line and multifunction pin
`default_nettype none
`include "phase_drive_regs.svh"
module phase_drive_sync_and_pin_mux
	import phase_drive_pkg::*;
#(
	parameter int unsigned NPH = `PHASE_COUNT_DEF,
	parameter int unsigned VW  = 16
) (
	// Clock and reset
	input  wire logic            clk_i,
	input  wire logic            nrst_i,
	// Enables and multifunction pin
	input  wire logic            chan_a_enable_in_i,
	input  wire logic            mf_pin_i,
	input  wire logic [1:0]      mf_mode_i,
	output logic                 mf_pin_o,
	output logic                 mf_pin_oe_o,
	// Sync configuration
	input  wire logic            pll_enable_i,
	input  wire logic            sync_master_i,
	input  wire logic [3:0]      sync_div_i,
	input  wire logic [15:0]     sync_phase_shift_i,
	input  wire logic [3:0]      sync_gain_i,
	input  wire logic [15:0]     on_time_i,
	input  wire logic [15:0]     period_i,
	// Phase control
	input  wire logic [NPH-1:0]  phase_chan_b_i,
	input  wire logic [NPH-1:0]  phase_active_i,
	// Voltage targets
	input  wire logic [VW-1:0]   vout_cmd_a_i,
	input  wire logic [VW-1:0]   vout_cmd_b_i,
	input  wire logic [VW-1:0]   vout_reset_val_i,
	output logic [VW-1:0]        vout_target_a_o,
	output logic [VW-1:0]        vout_target_b_o,
	// Stage fault lines and telemetry
	input  wire logic [1:0]      fault_line_high_i,
	input  wire logic [1:0]      fault_line_low_i,
	input  wire logic [15:0]     chan_a_temp_sense_in_i,
	input  wire logic [15:0]     chan_b_temp_sense_in_i,
	input  wire logic [NPH-1:0][15:0] phase_current_sense_in_i,
	input  wire logic [15:0]     stage_reference_in_i,
	input  wire logic            stage_fault_ignore_i,
	output logic [1:0][15:0]     temp_c_o,
	output logic [NPH-1:0][15:0] phase_amps_o,
	output logic [1:0]           stage_lockout_o,
	// Phase outputs and status
	output logic [NPH-1:0]       pwm_o,
	output logic [NPH-1:0]       pwm_oe_o,
	output logic                 catastrophic_fault_n_o,
	output logic                 catastrophic_fault_oe_o,
	output logic [1:0]           channel_power_good_o,
	output logic [1:0]           channel_power_good_oe_o,
	output logic                 pll_locked_o
);
	// ****************************************
	// Multifunction pin decode
	// ****************************************
	logic        en_a;
	logic        en_b;
	logic        vout_reset;
	logic        sync_in;
	logic        sync_d1_q;
	logic        sync_edge;
	logic [1:0]  run;
	logic        fault_q;
	if (NPH < 1 || NPH > 7) begin : g_bad_nph
		$error("phase count out of range");
	end
	assign en_a       = chan_a_enable_in_i;
	assign en_b       = (mf_mode_i == `MF_MODE_CHAN_B_EN) ? mf_pin_i : chan_a_enable_in_i;
	assign vout_reset = (mf_mode_i == `MF_MODE_VOUT_RESET) && !mf_pin_i;
	assign sync_in    = (mf_mode_i == `MF_MODE_SYNC) && !sync_master_i && mf_pin_i;
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			sync_d1_q <= 1'b0;
		end else begin
			sync_d1_q <= sync_in;
		end
	end
	assign sync_edge = sync_in && !sync_d1_q;
	// ****************************************
	// Voltage targets
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			vout_target_a_o <= '0;
			vout_target_b_o <= '0;
		end else begin
			vout_target_a_o <= vout_reset ? vout_reset_val_i : vout_cmd_a_i;
			vout_target_b_o <= vout_reset ? vout_reset_val_i : vout_cmd_b_i;
		end
	end
	// ****************************************
	// Fault line and run state
	// ****************************************
	assign stage_lockout_o = fault_line_low_i;
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			fault_q <= 1'b0;
		end else if (|fault_line_high_i && !stage_fault_ignore_i) begin
			fault_q <= 1'b1;
		end else if (!en_a && !en_b) begin
			fault_q <= 1'b0;
		end
	end
	assign run[0] = en_a && !fault_q && !fault_line_low_i[0];
	assign run[1] = en_b && !fault_q && !fault_line_low_i[1];
	assign catastrophic_fault_n_o  = 1'b0;
	assign catastrophic_fault_oe_o = fault_q;
	assign channel_power_good_o    = 2'b00;
	assign channel_power_good_oe_o = ~run;
	// ****************************************
	// Telemetry
	// ****************************************
	function automatic logic [15:0] temp_conv(input logic [15:0] mv);
		temp_conv = (mv - `TEMP_OFFSET_MV) / `TEMP_STEP_MV;
	endfunction
	assign temp_c_o[0] = temp_conv(chan_a_temp_sense_in_i);
	assign temp_c_o[1] = temp_conv(chan_b_temp_sense_in_i);
	genvar g;
	generate
		for (g = 0; g < NPH; g++) begin : g_amp
			assign phase_amps_o[g] =
				(phase_current_sense_in_i[g] - stage_reference_in_i) / `ISENSE_GAIN_MV_PER_A;
		end
	endgenerate
	// ****************************************
	// Switching timebase and PLL
	// ****************************************
	logic [15:0]        tb_q;
	logic signed [15:0] trim;
	logic               pwm0_edge;
	logic [15:0]        on_eff;
	assign pwm0_edge = (tb_q == 16'h0000);
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			tb_q <= 16'h0000;
		end else begin
			tb_q <= (tb_q >= period_i) ? 16'h0000 : tb_q + 16'h0001;
		end
	end
	sync_pll #(
		.W(16)
	) u_pll (
		.clk_i         (clk_i),
		.nrst_i        (nrst_i),
		.enable_i      (pll_enable_i && mf_mode_i == `MF_MODE_SYNC && !sync_master_i),
		.div_ratio_i   (sync_div_i),
		.phase_shift_i (sync_phase_shift_i),
		.gain_shift_i  (sync_gain_i),
		.sync_edge_i   (sync_edge),
		.pwm0_edge_i   (pwm0_edge),
		.trim_o        (trim),
		.locked_o      (pll_locked_o)
	);
	assign on_eff = on_time_i + trim;
	assign mf_pin_o    = (tb_q < (period_i >> 1)); // Master drives clock high while timebase is below period_i/2 (4 of 9 counts at period 8)
	assign mf_pin_oe_o = (mf_mode_i == `MF_MODE_SYNC) && sync_master_i;
	// ****************************************
	// Per phase three-state drive
	// ****************************************
	generate
		for (g = 0; g < NPH; g++) begin : g_ph
			phase_state_type st_q;
			logic            want;
			logic            hi_win;
			assign want   = phase_active_i[g] && run[phase_chan_b_i[g]];
			assign hi_win = (tb_q < on_eff);
			always_ff @(posedge clk_i) begin
				if (!nrst_i) begin
					st_q <= ph_off;
				end else begin
					unique case (st_q)
						ph_off:  if (want && pwm0_edge) st_q <= ph_high;
						ph_high: if (!hi_win) st_q <= ph_low;
						ph_low: begin
							if (!want) st_q <= ph_off;
							else if (hi_win) st_q <= ph_high;
						end
						default: st_q <= ph_off;
					endcase
				end
			end
			assign pwm_o[g]    = (st_q == ph_high);
			assign pwm_oe_o[g] = (st_q != ph_off);
		end
	endgenerate
endmodule
`default_nettype wire

/* phase_drive_asserts.sv */
// Port checker for the phase drive block
`default_nettype none
module phase_drive_asserts #(
	parameter int unsigned NPH = 2,
	parameter int unsigned VW = 16
) (
	// Watched ports
	input wire logic		clk_i,
	input wire logic		nrst_i,
	input wire logic		chan_a_enable_in_i,
	input wire logic		mf_pin_i,
	input wire logic [1:0]		mf_mode_i,
	input wire logic [VW-1:0]	vout_cmd_a_i,
	input wire logic [VW-1:0]	vout_reset_val_i,
	input wire logic [VW-1:0]	vout_target_a_o,
	input wire logic [1:0]		fault_line_high_i,
	input wire logic [1:0]		fault_line_low_i,
	input wire logic		stage_fault_ignore_i,
	input wire logic [15:0]		chan_a_temp_sense_in_i,
	input wire logic [1:0][15:0]	temp_c_o,
	input wire logic [1:0]		stage_lockout_o,
	input wire logic [NPH-1:0]	pwm_o,
	input wire logic [NPH-1:0]	pwm_oe_o,
	input wire logic		catastrophic_fault_oe_o,
	input wire logic [1:0]		channel_power_good_oe_o
);
	// ****
	// Checks
	// ****
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	rst_target_a: assert property (mf_mode_i == 2'h1 && !mf_pin_i
		|=> vout_target_a_o == $past(vout_reset_val_i)) else $error("reset target wrong");
	cmd_target_a: assert property ((mf_mode_i != 2'h1 || mf_pin_i)
		|=> vout_target_a_o == $past(vout_cmd_a_i)) else $error("target not command");
	start_high_a: assert property ($rose(pwm_oe_o[0]) |-> pwm_o[0])
		else $error("phase start not high");
	stop_low_a: assert property ($fell(pwm_oe_o[0]) |-> !$past(pwm_o[0]))
		else $error("phase stop not from low");
	stage_fault_a: assert property (fault_line_high_i[0] && !stage_fault_ignore_i
		|-> ##[0:2] catastrophic_fault_oe_o) else $error("fault not raised");
	lockout_a: assert property (fault_line_low_i[0]
		|-> stage_lockout_o[0] && channel_power_good_oe_o[0]) else $error("lockout wrong");
	temp_scale_a: assert property (chan_a_temp_sense_in_i >= 16'h0258
		|-> temp_c_o[0] == (chan_a_temp_sense_in_i - 16'h0258) / 16'h0008) else $error("temp");
	pgood_low_a: assert property (!chan_a_enable_in_i
		|-> ##[0:2] channel_power_good_oe_o[0]) else $error("power good not low");
	cover property ($rose(pwm_oe_o[0]));
	cover property ($fell(pwm_oe_o[0]));
	cover property (catastrophic_fault_oe_o);
endmodule
bind phase_drive_sync_and_pin_mux phase_drive_asserts #(.NPH(NPH), .VW(VW)) u_chk (.*);
`default_nettype wire

/* stage_model.sv */
// Power stage model for the phase drive block
`default_nettype none
module stage_model #(
	parameter int unsigned NPH     = 2,
	parameter int unsigned HALF_NS = 225
) (
	// Bench commands
	input wire logic		fault_cmd_i,
	input wire logic		uvlo_cmd_i,
	input wire logic		sync_run_i,
	input wire logic [15:0]		amps_i,
	input wire logic [15:0]		ref_i,
	// Lines to the controller
	output logic [1:0]		fault_line_high_o,
	output logic [1:0]		fault_line_low_o,
	output logic [NPH-1:0][15:0]	sense_o,
	output logic			sync_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Stage lines
	// ****
	assign fault_line_high_o = {1'b0, fault_cmd_i};
	assign fault_line_low_o = {1'b0, uvlo_cmd_i};
	always_comb begin
		for (int i = 0; i < NPH; i++) begin
			sense_o[i] = ref_i + amps_i * 16'h0005;
		end
	end
	// ****
	// External sync clock
	// ****
	// Full period matches the nine cycle timebase; offset keeps edges off clk
	initial begin
		sync_o = 1'b0;
		forever begin
			wait (sync_run_i);
			#5;
			while (sync_run_i) begin
				sync_o = ~sync_o;
				#(HALF_NS);
			end
			sync_o = 1'b0;
		end
	end
endmodule
`default_nettype wire

/* tb_phase_drive_sync_and_pin_mux.sv */
// Testbench for the phase drive block
`default_nettype none
module tb_phase_drive_sync_and_pin_mux;
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Bench
	// ****
	logic clk_i = 0, nrst_i = 0, en_a = 0, mf_pin = 1, f_cmd = 0, u_cmd = 0, ign = 0;
	logic pll_en = 0, master = 0, sync_run = 0, sync_clk, mf_in, mf_o, mf_oe, cf_n, cf_oe, locked;
	logic [1:0] mf_mode = 2'h0, f_hi, f_lo, lock, pg_oe, pg;
	logic [1:0] chan_b = 2'b10, active = 2'b00, pwm, pwm_oe;
	logic [15:0] cmd_a = 16'h0384, cmd_b = 16'h0320, rst_v = 16'h01F4, amps = 16'h0000;
	logic [15:0] temp_a = 16'h0258, temp_b = 16'h0258, vref = 16'h05DC, tgt_a, tgt_b;
	logic [1:0][15:0] sense, temp_c, ph_a;
	int fail_count = 0;
	int total_checks = 0;
	assign mf_in = (mf_mode == 2'h2) ? sync_clk : mf_pin;
	stage_model #(.NPH(2)) u_stage (.fault_cmd_i(f_cmd), .uvlo_cmd_i(u_cmd), .amps_i(amps),
		.ref_i(vref), .fault_line_high_o(f_hi), .fault_line_low_o(f_lo), .sense_o(sense),
		.sync_run_i(sync_run), .sync_o(sync_clk));
	phase_drive_sync_and_pin_mux #(.NPH(2), .VW(16)) u_dut (.clk_i(clk_i), .nrst_i(nrst_i),
		.chan_a_enable_in_i(en_a), .mf_pin_i(mf_in), .mf_mode_i(mf_mode), .mf_pin_o(mf_o),
		.mf_pin_oe_o(mf_oe), .pll_enable_i(pll_en), .sync_master_i(master), .sync_div_i(4'h0),
		.sync_phase_shift_i(16'h0000), .sync_gain_i(4'h0), .on_time_i(16'h0003),
		.period_i(16'h0008), .phase_chan_b_i(chan_b), .phase_active_i(active),
		.vout_cmd_a_i(cmd_a), .vout_cmd_b_i(cmd_b), .vout_reset_val_i(rst_v),
		.vout_target_a_o(tgt_a), .vout_target_b_o(tgt_b), .fault_line_high_i(f_hi),
		.fault_line_low_i(f_lo), .chan_a_temp_sense_in_i(temp_a), .chan_b_temp_sense_in_i(temp_b),
		.phase_current_sense_in_i(sense), .stage_reference_in_i(vref),
		.stage_fault_ignore_i(ign), .temp_c_o(temp_c), .phase_amps_o(ph_a),
		.stage_lockout_o(lock), .pwm_o(pwm), .pwm_oe_o(pwm_oe), .catastrophic_fault_n_o(cf_n),
		.catastrophic_fault_oe_o(cf_oe), .channel_power_good_o(pg),
		.channel_power_good_oe_o(pg_oe), .pll_locked_o(locked));
	initial forever #25 clk_i = ~clk_i;
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d failures %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wait_for(input logic v, input bit on_oe);
		int n;
		n = 0;
		while (((on_oe ? pwm_oe[0] : pwm[0]) !== v) && n < 40) begin
			cyc(1);
			n++;
		end
		if (n == 40) begin
			fail_count++;
			finish_test();
		end
	endtask
	task automatic t_phase();
		@(posedge clk_i);
		en_a <= 1'b1;
		active <= 2'b01;
		cyc(1);
		wait_for(1'b1, 1'b1);
		check(pwm[0], 1'b1);
		wait_for(1'b0, 1'b0);
		check(pwm_oe[0], 1'b1);
		@(posedge clk_i);
		mf_mode <= 2'h1;
		mf_pin <= 1'b0;
		cyc(2);
		check(tgt_a, rst_v);
		check(tgt_b, rst_v);
		check(pwm_oe[0], 1'b1);
		check(pg_oe, 2'h0);
		@(posedge clk_i);
		mf_pin <= 1'b1;
		cyc(2);
		check(tgt_a, cmd_a);
		check(tgt_b, cmd_b);
		wait_for(1'b0, 1'b0);
		wait_for(1'b1, 1'b0);
		@(posedge clk_i);
		active <= 2'b00;
		cyc(1);
		check(pwm[0], 1'b1);
		check(pwm_oe[0], 1'b1);
		wait_for(1'b0, 1'b1);
		@(posedge clk_i);
		en_a <= 1'b0;
		cyc(3);
		check(pg_oe, 2'h3);
	endtask
	task automatic t_fault();
		@(posedge clk_i);
		mf_mode <= 2'h0;
		en_a <= 1'b1;
		f_cmd <= 1'b1;
		cyc(3);
		check(cf_oe, 1'b1);
		check(cf_n, 1'b0);
		check(pg_oe, 2'h3);
		check(pg, 2'h0);
		@(posedge clk_i);
		f_cmd <= 1'b0;
		en_a <= 1'b0;
		mf_pin <= 1'b0;
		cyc(3);
		check(cf_oe, 1'b0);
		check(pg_oe[0], 1'b1);
		@(posedge clk_i);
		ign <= 1'b1;
		f_cmd <= 1'b1;
		u_cmd <= 1'b1;
		cyc(3);
		check(cf_oe, 1'b0);
		check(lock, 2'b01);
	endtask
	task automatic t_tele();
		@(posedge clk_i);
		temp_a <= 16'h0320;
		amps <= 16'h000A;
		cyc(1);
		check(temp_c[0], 16'h0019);
		check(temp_c[1], 16'h0000);
		check(ph_a[0], 16'h000A);
		check(ph_a[1], 16'h000A);
	endtask
	task automatic t_sync();
		int highs;
		highs = 0;
		@(posedge clk_i);
		f_cmd <= 1'b0;
		u_cmd <= 1'b0;
		ign <= 1'b0;
		mf_mode <= 2'h2;
		master <= 1'b1;
		en_a <= 1'b1;
		cyc(1);
		check(mf_oe, 1'b1);
		check(locked, 1'b0);
		check(pg_oe, 2'h0);
		repeat (9) begin
			highs += mf_o;
			cyc(1);
		end
		check(highs, 32'h4);
		@(posedge clk_i);
		master <= 1'b0;
		pll_en <= 1'b1;
		sync_run <= 1'b1;
		cyc(1);
		check(mf_oe, 1'b0);
		cyc(40);
		check(locked, 1'b1);
		@(posedge clk_i);
		sync_run <= 1'b0;
		pll_en <= 1'b0;
		cyc(1);
		check(locked, 1'b0);
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		nrst_i <= 1'b1;
		t_phase();
		t_fault();
		t_tele();
		t_sync();
		finish_test();
	end
endmodule
`default_nettype wire
